// >>> core/hpc_pkg.sv
// Constants and types shared by the hibernation power controller files.
// Assumes a 100 MHz system clock; the reference enters as a plain pin.
package hpc_pkg;
    localparam int unsigned SYS_CLK_HZ   = 100_000_000;
    localparam int          RTC_W        = 32;
    localparam int          TRIM_W       = 16;
    localparam int          MEM_DEPTH    = 64;
    localparam int          MEM_AW       = 6;
    localparam int          DIV_W        = 7;
    localparam int          EPOCH_W      = 6;
    // Crystal is divided by 128 to reach the 32.768 kHz reference
    localparam logic [DIV_W-1:0]   XTAL_DIV_LAST = 7'h7f;
    localparam logic [TRIM_W-1:0]  TRIM_RESET    = 16'h7fff;
    localparam logic [TRIM_W-1:0]  TRIM_ZERO     = 16'h0000;
    // Trim is taken over once every 64 seconds
    localparam logic [EPOCH_W-1:0] EPOCH_LAST    = 6'h3f;
    // Event bit positions in the status vectors
    localparam int EV_MATCH = 0;
    localparam int EV_LOWBAT = 1;
    localparam int EV_WAKE  = 2;
    localparam int EV_W     = 3;

    typedef enum logic [0:0] {
        st_active = 1'b0,
        st_asleep = 1'b1
    } hpc_state_type;
endpackage : hpc_pkg

// >>> core/hpc_tick_if.sv
// Tick and trim signals between the main controller and the tick maker.
// Both ends run on the system clock.
`timescale 1ns/1ns
interface hpc_tick_if;
    logic                          ref_tick;
    logic                          sec_tick;
    logic                          trim_load;
    logic [hpc_pkg::TRIM_W-1:0]    trim_value;

    modport gen (output ref_tick, output sec_tick,
                 input trim_load, input trim_value);
    modport use_side (input ref_tick, input sec_tick,
                      output trim_load, output trim_value);
endinterface : hpc_tick_if

// >>> core/hpc_tick_gen.sv
// Reference clock pin to 32.768 kHz tick and one-second tick.
// Reference pin is asynchronous; trim reload comes from the main block.
`timescale 1ns/1ns
module hpc_tick_gen (
    input  wire logic   sys_clk_in,
    input  wire logic   rst_n_in,
    input  wire logic   ref_pin_in,
    input  wire logic   osc_enable_in,
    input  wire logic   osc_type_select_in,
    hpc_tick_if.gen     tick
);
    logic                       sync1_q, sync2_q, sync3_q;
    logic [hpc_pkg::DIV_W-1:0]  div_q, div_d;
    logic [hpc_pkg::TRIM_W-1:0] pre_q, pre_d;
    logic [hpc_pkg::TRIM_W-1:0] reload_q, reload_d;
    logic                       ref_q, ref_d;
    logic                       sec_q, sec_d;
    logic                       ref_edge;

    always_comb begin
        ref_edge = sync2_q & ~sync3_q & osc_enable_in;
        div_d    = div_q;
        ref_d    = 1'b0;
        if (osc_type_select_in) begin
            div_d = '0;
            ref_d = ref_edge;
        end else if (ref_edge) begin
            if (div_q == hpc_pkg::XTAL_DIV_LAST) begin
                div_d = '0;
                ref_d = 1'b1;
            end else begin
                div_d = div_q + 1'b1;
            end
        end
        reload_d = tick.trim_load ? tick.trim_value : reload_q;
        pre_d    = pre_q;
        sec_d    = 1'b0;
        if (ref_q) begin
            if (pre_q == hpc_pkg::TRIM_ZERO) begin
                pre_d = reload_q;
                sec_d = 1'b1;
            end else begin
                pre_d = pre_q - 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync1_q  <= 1'b0;
            sync2_q  <= 1'b0;
            sync3_q  <= 1'b0;
            div_q    <= '0;
            pre_q    <= hpc_pkg::TRIM_RESET;
            reload_q <= hpc_pkg::TRIM_RESET;
            ref_q    <= 1'b0;
            sec_q    <= 1'b0;
        end else begin
            sync1_q  <= ref_pin_in;
            sync2_q  <= sync1_q;
            sync3_q  <= sync2_q;
            div_q    <= div_d;
            pre_q    <= pre_d;
            reload_q <= reload_d;
            ref_q    <= ref_d;
            sec_q    <= sec_d;
        end
    end

    assign tick.ref_tick = ref_q;
    assign tick.sec_tick = sec_q;
endmodule : hpc_tick_gen

// >>> core/hpc_power_control.sv
// Hibernation power controller: counter, matches, power-off pin, events,
// retained words. Control arrives as plain ports from same-clock logic;
// wake, low-battery and reference pins are asynchronous.
`timescale 1ns/1ns
// How it works
// - Active-low power-off output switches the external regulator off.
// - In hibernation an asserted wake pin releases power-off.
// - In hibernation a counter match releases power-off.
// - Low battery is detected; with abort set, hibernation is refused.
// - A 32-bit seconds counter runs from the reference tick.
// - Two 32-bit match values act as wake or interrupt sources.
// - Reference is a 32.768 kHz oscillator or a 4.194304 MHz crystal.
// - A software trim predivider sets the counting rate.
// - Sixty-four retained 32-bit words survive hibernation.
// - Match, wake pin and low battery raise maskable events.
// - Predivider counts down from 0x7fff, one tick per second.
// - Select low divides input by 128, high uses it directly.
// - Enabled events are ORed onto one interrupt request.
module hpc_power_control (
    input  wire logic                        sys_clk_in,
    input  wire logic                        rst_n_in,
    input  wire logic                        ref_pin_in,
    input  wire logic                        osc_enable_in,
    input  wire logic                        osc_type_select_in,
    input  wire logic                        wake_n_in,
    input  wire logic                        low_batt_in,
    input  wire logic                        rtc_enable_in,
    input  wire logic                        rtc_load_in,
    input  wire logic [hpc_pkg::RTC_W-1:0]   rtc_load_value_in,
    input  wire logic [hpc_pkg::TRIM_W-1:0]  trim_value_in,
    input  wire logic [hpc_pkg::RTC_W-1:0]   match0_in,
    input  wire logic [hpc_pkg::RTC_W-1:0]   match1_in,
    input  wire logic                        pin_wake_enable_in,
    input  wire logic                        rtc_wake_enable_in,
    input  wire logic                        low_batt_enable_in,
    input  wire logic                        low_batt_abort_in,
    input  wire logic                        sleep_request_bit_in,
    input  wire logic [hpc_pkg::EV_W-1:0]    event_mask_in,
    input  wire logic [hpc_pkg::EV_W-1:0]    event_clear_in,
    input  wire logic                        mem_write_in,
    input  wire logic [hpc_pkg::MEM_AW-1:0]  mem_addr_in,
    input  wire logic [hpc_pkg::RTC_W-1:0]   mem_wdata_in,
    output logic                             power_off_n_out,
    output logic                             hibernating_out,
    output logic                             irq_out,
    output logic [hpc_pkg::EV_W-1:0]         raw_status_out,
    output logic [hpc_pkg::EV_W-1:0]         masked_status_out,
    output logic [hpc_pkg::RTC_W-1:0]        rtc_value_out,
    output logic [hpc_pkg::RTC_W-1:0]        mem_rdata_out
);
    hpc_tick_if tick ();

    hpc_tick_gen u_tick (
        .sys_clk_in         (sys_clk_in),
        .rst_n_in           (rst_n_in),
        .ref_pin_in         (ref_pin_in),
        .osc_enable_in      (osc_enable_in),
        .osc_type_select_in (osc_type_select_in),
        .tick               (tick.gen)
    );

    // Pin synchronisers
    logic wake_s1_q, wake_s2_q, bat_s1_q, bat_s2_q;

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wake_s1_q <= 1'b1;
            wake_s2_q <= 1'b1;
            bat_s1_q  <= 1'b0;
            bat_s2_q  <= 1'b0;
        end else begin
            wake_s1_q <= wake_n_in;
            wake_s2_q <= wake_s1_q;
            bat_s1_q  <= low_batt_in;
            bat_s2_q  <= bat_s1_q;
        end
    end

    // Counter, pending load, trim epoch
    logic [hpc_pkg::RTC_W-1:0]   rtc_q, rtc_d, ld_val_q, ld_val_d;
    logic                        ld_pend_q, ld_pend_d;
    logic [hpc_pkg::EPOCH_W-1:0] epoch_q, epoch_d;
    logic                        trim_ld_q, trim_ld_d;
    logic                        match_q, match_d;
    logic                        rtc_step;

    always_comb begin
        rtc_step  = tick.sec_tick & rtc_enable_in;
        rtc_d     = rtc_q;
        ld_pend_d = ld_pend_q | rtc_load_in;
        ld_val_d  = rtc_load_in ? rtc_load_value_in : ld_val_q;
        if (ld_pend_q && tick.ref_tick) begin
            rtc_d     = ld_val_q;
            ld_pend_d = rtc_load_in;
        end else if (rtc_step) begin
            rtc_d = rtc_q + 1'b1;
        end
        epoch_d   = rtc_step ? epoch_q + 1'b1 : epoch_q;
        trim_ld_d = rtc_step && (epoch_q == hpc_pkg::EPOCH_LAST);
        // A match fires once, when the counter moves onto the value
        match_d = (rtc_d != rtc_q) &&
                  ((rtc_d == match0_in) || (rtc_d == match1_in));
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rtc_q     <= '0;
            ld_val_q  <= '0;
            ld_pend_q <= 1'b0;
            epoch_q   <= '0;
            trim_ld_q <= 1'b0;
            match_q   <= 1'b0;
        end else begin
            rtc_q     <= rtc_d;
            ld_val_q  <= ld_val_d;
            ld_pend_q <= ld_pend_d;
            epoch_q   <= epoch_d;
            trim_ld_q <= trim_ld_d;
            match_q   <= match_d;
        end
    end

    assign tick.trim_load  = trim_ld_q;
    assign tick.trim_value = trim_value_in;

    // Hibernation sequencing
    hpc_pkg::hpc_state_type state_q, state_d;
    logic                   pwr_n_q, pwr_n_d;
    logic                   low_bat, wake_pin, abort_now, has_source;

    always_comb begin
        low_bat    = bat_s2_q & low_batt_enable_in;
        wake_pin   = ~wake_s2_q;
        abort_now  = low_bat & low_batt_abort_in;
        has_source = pin_wake_enable_in | rtc_wake_enable_in;
        state_d    = state_q;
        pwr_n_d    = pwr_n_q;
        unique case (state_q)
            hpc_pkg::st_active: begin
                if (sleep_request_bit_in && has_source && !abort_now) begin
                    state_d = hpc_pkg::st_asleep;
                    pwr_n_d = 1'b0;
                end
            end
            hpc_pkg::st_asleep: begin
                if ((pin_wake_enable_in && wake_pin) ||
                    (rtc_wake_enable_in && match_q)) begin
                    state_d = hpc_pkg::st_active;
                    pwr_n_d = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= hpc_pkg::st_active;
            pwr_n_q <= 1'b1;
        end else begin
            state_q <= state_d;
            pwr_n_q <= pwr_n_d;
        end
    end

    // Sticky events; a set in the clearing cycle wins
    logic [hpc_pkg::EV_W-1:0] raw_q, raw_d, set_ev, msk_q, msk_d;
    logic                     irq_q, irq_d;

    always_comb begin
        set_ev = '0;
        set_ev[hpc_pkg::EV_MATCH]  = match_q;
        set_ev[hpc_pkg::EV_LOWBAT] = low_bat;
        set_ev[hpc_pkg::EV_WAKE]   = wake_pin;
        raw_d = (raw_q & ~event_clear_in) | set_ev;
        msk_d = raw_d & event_mask_in;
        irq_d = |msk_d;
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            raw_q <= '0;
            msk_q <= '0;
            irq_q <= 1'b0;
        end else begin
            raw_q <= raw_d;
            msk_q <= msk_d;
            irq_q <= irq_d;
        end
    end

    // Retained words: no reset so contents survive
    logic [hpc_pkg::RTC_W-1:0] mem [hpc_pkg::MEM_DEPTH];
    logic [hpc_pkg::RTC_W-1:0] rdata_q, rdata_d;

    always_comb begin
        rdata_d = mem[mem_addr_in];
    end

    always_ff @(posedge sys_clk_in) begin
        if (mem_write_in) begin
            mem[mem_addr_in] <= mem_wdata_in;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign power_off_n_out   = pwr_n_q;
    assign hibernating_out   = (state_q == hpc_pkg::st_asleep);
    assign irq_out           = irq_q;
    assign raw_status_out    = raw_q;
    assign masked_status_out = msk_q;
    assign rtc_value_out     = rtc_q;
    assign mem_rdata_out     = rdata_q;
endmodule : hpc_power_control

// >>> verif/hpc_regulator_model.sv
// Regulator and wake-pin partner for the hibernation power controller.
// Assumes the bench commands wake and oscillator activity off the edge.
`timescale 1ns/1ns
module hpc_regulator_model (
    input  wire logic sys_clk_in,
    input  wire logic power_off_n_in,
    input  wire logic run_ref_in,
    input  wire logic assert_wake_in,
    output logic      ref_pin_out,
    output logic      wake_n_out,
    output logic      powered_out
);
    logic [1:0] div_q = 2'h0;
    // Regulator supplies the core only while its enable is high
    assign powered_out = power_off_n_in;
    // Wake pin has a pull-up and reads high unless pulled down
    assign wake_n_out  = ~assert_wake_in;
    // Reference stands still low unless the oscillator runs
    // Toggles every clock so a counted second fits in a short run
    assign ref_pin_out = run_ref_in & div_q[0];
    always @(posedge sys_clk_in) div_q <= div_q + 2'h1;
endmodule : hpc_regulator_model

// >>> verif/hpc_power_control_sva.sv
// Checker for the hibernation power controller, bound to its top ports.
// Assumes one clock, sys_clk_in, and the active-low reset rst_n_in.
`timescale 1ns/1ns
module hpc_power_control_sva (
    input wire logic                       sys_clk_in,
    input wire logic                       rst_n_in,
    input wire logic                       wake_n_in,
    input wire logic                       low_batt_in,
    input wire logic                       pin_wake_enable_in,
    input wire logic                       rtc_wake_enable_in,
    input wire logic                       low_batt_enable_in,
    input wire logic                       low_batt_abort_in,
    input wire logic                       sleep_request_bit_in,
    input wire logic [hpc_pkg::EV_W-1:0]   event_mask_in,
    input wire logic [hpc_pkg::EV_W-1:0]   event_clear_in,
    input wire logic                       mem_write_in,
    input wire logic [hpc_pkg::MEM_AW-1:0] mem_addr_in,
    input wire logic [hpc_pkg::RTC_W-1:0]  mem_wdata_in,
    input wire logic                       power_off_n_out,
    input wire logic                       hibernating_out,
    input wire logic                       irq_out,
    input wire logic [hpc_pkg::EV_W-1:0]   raw_status_out,
    input wire logic [hpc_pkg::EV_W-1:0]   masked_status_out,
    input wire logic [hpc_pkg::RTC_W-1:0]  mem_rdata_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_wake_held;
        (hibernating_out && pin_wake_enable_in && !wake_n_in) ##1
        (!wake_n_in && pin_wake_enable_in)[*2];
    endsequence
    sequence s_lowbat_abort;
        (low_batt_in && low_batt_enable_in && low_batt_abort_in)[*3];
    endsequence
    chk_request_powers_off: assert property (
        sleep_request_bit_in && !hibernating_out && pin_wake_enable_in &&
        !low_batt_enable_in |=> !power_off_n_out && hibernating_out)
        else $error("request did not remove power");
    chk_power_state_tie: assert property (
        power_off_n_out == !hibernating_out)
        else $error("power output disagrees with state");
    chk_pin_wake_time: assert property (
        s_wake_held |=> power_off_n_out)
        else $error("wake pin did not restore power");
    chk_abort_refuses: assert property (
        s_lowbat_abort ##0 (sleep_request_bit_in && !hibernating_out)
        |=> !hibernating_out)
        else $error("hibernation entered on low battery");
    chk_lowbat_status: assert property (
        (low_batt_in && low_batt_enable_in)[*4] |-> raw_status_out[1])
        else $error("low battery status not raised");
    chk_masked_status: assert property (
        $stable(event_mask_in) |->
        masked_status_out == (raw_status_out & event_mask_in))
        else $error("masked status wrong");
    chk_irq_or: assert property (
        irq_out == |masked_status_out)
        else $error("interrupt not the OR of masked status");
    chk_clear_wake: assert property (
        wake_n_in[*3] ##0 event_clear_in[2] |=> !raw_status_out[2])
        else $error("wake status not cleared");
    chk_mem_read: assert property (
        mem_write_in ##1 (!mem_write_in && $stable(mem_addr_in))
        |=> mem_rdata_out == $past(mem_wdata_in, 2))
        else $error("retained word read back wrong");
endmodule : hpc_power_control_sva
bind hpc_power_control hpc_power_control_sva hpc_power_control_sva_i (.*);

// >>> verif/hpc_power_control_tb.sv
// Self-checking bench for the hibernation power controller.
// Assumes the partner model drives the reference and wake pins.
`timescale 1ns/1ns
module hpc_power_control_tb;
    typedef struct {logic [5:0] a; logic [31:0] d;} hpc_row_type;
    logic sys_clk_in, rst_n_in, ref_pin_in, wake_n_in, low_batt_in;
    logic osc_enable_in, osc_type_select_in, rtc_enable_in, rtc_load_in;
    logic pin_wake_enable_in, rtc_wake_enable_in, low_batt_enable_in;
    logic low_batt_abort_in, sleep_request_bit_in, mem_write_in;
    logic power_off_n_out, hibernating_out, irq_out, powered;
    logic run_ref, assert_wake;
    logic [31:0] rtc_load_value_in, match0_in, match1_in, mem_wdata_in;
    logic [31:0] rtc_value_out, mem_rdata_out, v;
    logic [15:0] trim_value_in;
    logic [2:0]  event_mask_in, event_clear_in, raw_status_out;
    logic [2:0]  masked_status_out;
    logic [5:0]  mem_addr_in;
    int          num_errors, tests_run, cycles, n;
    hpc_row_type rows [4] = '{'{6'h00, 32'h0000_0001},
        '{6'h3f, 32'hffff_ffff}, '{6'h15, 32'ha5a5_5a5a}, '{6'h2a, 32'h0}};
    hpc_power_control hpc_power_control_i (.*);
    hpc_regulator_model hpc_regulator_model_i (.sys_clk_in(sys_clk_in),
        .power_off_n_in(power_off_n_out), .run_ref_in(run_ref),
        .assert_wake_in(assert_wake), .ref_pin_out(ref_pin_in),
        .wake_n_out(wake_n_in), .powered_out(powered));
    initial sys_clk_in = 1'b0;
    always #5 sys_clk_in = ~sys_clk_in;
    task automatic check(string name, logic [31:0] exp, logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic results();
        if (num_errors == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : results
    task automatic request();
        @(negedge sys_clk_in) sleep_request_bit_in = 1'b1;
        @(negedge sys_clk_in) sleep_request_bit_in = 1'b0;
    endtask : request
    task automatic clear_ev(logic [2:0] bits);
        @(negedge sys_clk_in) event_clear_in = bits;
        @(negedge sys_clk_in) event_clear_in = 3'h0;
        @(negedge sys_clk_in);
    endtask : clear_ev
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 70000) begin
            num_errors++;
            results();
        end
    end
    initial begin
        {rst_n_in, low_batt_in, osc_enable_in, osc_type_select_in} = 4'h0;
        {rtc_enable_in, rtc_load_in, pin_wake_enable_in} = 3'h0;
        {rtc_wake_enable_in, low_batt_enable_in, low_batt_abort_in} = 3'h0;
        {sleep_request_bit_in, mem_write_in, run_ref, assert_wake} = 4'h0;
        {rtc_load_value_in, match0_in, match1_in, mem_wdata_in} = 128'h0;
        {trim_value_in, event_mask_in, event_clear_in, mem_addr_in} = 28'h0;
        repeat (3) @(negedge sys_clk_in);
        rst_n_in = 1'b1;
        check("power_off_n", 32'h1, power_off_n_out);
        check("rtc_value", 32'h0, rtc_value_out);
        foreach (rows[i]) begin
            {mem_write_in, mem_addr_in, mem_wdata_in} =
                {1'b1, rows[i].a, rows[i].d};
            @(negedge sys_clk_in) mem_write_in = 1'b0;
            @(negedge sys_clk_in);
            check("mem_rdata", rows[i].d, mem_rdata_out);
        end
        request();
        check("no_source_hib", 32'h0, hibernating_out);
        {pin_wake_enable_in, event_mask_in} = 4'hf;
        request();
        check("powered", 32'h0, powered);
        assert_wake = 1'b1;
        for (n = 0; power_off_n_out !== 1'b1 && n < 10; n++)
            @(negedge sys_clk_in);
        check("wake_cycles", 32'h3, n);
        check("wake_status", 32'h4, raw_status_out);
        check("masked_status", 32'h4, masked_status_out);
        check("irq", 32'h1, irq_out);
        assert_wake = 1'b0;
        repeat (3) @(negedge sys_clk_in);
        clear_ev(3'h4);
        check("irq_clear", 32'h0, irq_out);
        foreach (rows[i]) begin
            @(negedge sys_clk_in) mem_addr_in = rows[i].a;
            @(negedge sys_clk_in);
            check("kept", rows[i].d, mem_rdata_out);
        end
        {low_batt_enable_in, low_batt_abort_in, low_batt_in} = 3'h7;
        repeat (4) @(negedge sys_clk_in);
        check("lowbat_status", 32'h1, raw_status_out[1]);
        request();
        check("abort_hib", 32'h0, hibernating_out);
        {low_batt_enable_in, low_batt_abort_in, low_batt_in} = 3'h0;
        repeat (3) @(negedge sys_clk_in);
        clear_ev(3'h2);
        {pin_wake_enable_in, rtc_wake_enable_in, osc_enable_in} = 3'h3;
        {osc_type_select_in, run_ref} = 2'h3;
        for (int k = 0; k < 2; k++) begin
            v = 32'h0000_1230 + k;
            match0_in = (k == 0) ? v : 32'hffff_0000;
            match1_in = (k == 1) ? v : 32'hffff_0000;
            request();
            check("rtc_hib", 32'h1, hibernating_out);
            {rtc_load_in, rtc_load_value_in} = {1'b1, v};
            @(negedge sys_clk_in) rtc_load_in = 1'b0;
            for (n = 0; power_off_n_out !== 1'b1 && n < 40; n++)
                @(negedge sys_clk_in);
            check("match_wake", 32'h1, power_off_n_out);
            check("rtc_loaded", v, rtc_value_out);
            check("match_status", 32'h1, raw_status_out[0]);
            clear_ev(3'h1);
        end
        osc_type_select_in = 1'b0;
        {rtc_load_in, rtc_load_value_in} = {1'b1, 32'h0000_00aa};
        @(negedge sys_clk_in) rtc_load_in = 1'b0;
        repeat (200) @(negedge sys_clk_in);
        check("div_early", v, rtc_value_out);
        for (n = 0; rtc_value_out !== 32'haa && n < 700; n++)
            @(negedge sys_clk_in);
        check("div_load", 32'haa, rtc_value_out);
        // Mid-run reset: rest values return, retained words survive
        rst_n_in = 1'b0;
        {osc_type_select_in, rtc_enable_in} = 2'h3;
        repeat (3) @(negedge sys_clk_in);
        rst_n_in = 1'b1;
        check("rst_power", 32'h1, power_off_n_out);
        check("rst_rtc", 32'h0, rtc_value_out);
        check("rst_status", 32'h0, raw_status_out);
        mem_addr_in = rows[2].a;
        @(negedge sys_clk_in);
        check("rst_kept", rows[2].d, mem_rdata_out);
        // Predivider starts at its nominal reload: one step per 0x8000 ticks
        repeat (65500) @(negedge sys_clk_in);
        check("sec_early", 32'h0, rtc_value_out);
        for (n = 0; rtc_value_out !== 32'h1 && n < 100; n++)
            @(negedge sys_clk_in);
        check("sec_step", 32'h1, rtc_value_out);
        results();
    end
endmodule : hpc_power_control_tb
